// >>> dv/rits_cpu_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// cpu core stand-in
// ----------------------------------------
module rits_cpu_model
  import rits_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // bench commands
  input wire logic i_run,
  input wire logic i_swi,
  input wire logic i_clr,
  input wire logic i_set,
  // sequencer side
  input wire rits_pkg::rits_seq_out_t i_seq,
  output rits_pkg::rits_cpu_req_t o_cpu
);
  logic swi_q, saved_q, mask_b_q, busy_q;
  logic [3:0] gap_q, ret_q;
  wire logic start = i_seq.busy && !busy_q;
  // no boundary while a return is still due, so the saved mask stays right
  wire logic issue = i_run && !i_seq.busy && !i_seq.in_reset &&
                     gap_q == 4'h0 && ret_q == 4'h0;
  wire logic svc_done = i_seq.vec_load && i_seq.vec_addr != VEC_RESET;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cpu <= '0;
      {swi_q, saved_q, mask_b_q, busy_q} <= 4'h0;
      gap_q <= 4'h0;
      ret_q <= 4'h0;
    end else begin
      busy_q <= i_seq.busy;
      o_cpu.boundary <= issue;
      o_cpu.software_trap_instruction <= issue && swi_q;
      o_cpu.mask_set <= i_set;
      o_cpu.mask_clr <= i_clr || (ret_q == 4'h1 && !saved_q);
      gap_q <= issue ? 4'h5 : gap_q - 4'(gap_q != 4'h0);
      if (issue) mask_b_q <= i_seq.mask;
      if (start) saved_q <= mask_b_q;
      // a trap deferred behind hardware is presented again
      if (i_swi) swi_q <= 1'b1;
      else if (start && i_seq.vec_addr == VEC_SWI) swi_q <= 1'b0;
      if (svc_done) ret_q <= 4'h8;
      else if (ret_q != 4'h0) ret_q <= ret_q - 4'h1;
    end
  end
endmodule

// >>> dv/tb_reset_interrupt_timer_sequencer.sv
`timescale 1ns/1ps
module tb_reset_interrupt_timer_sequencer;
  import rits_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, prdata2, r, r2, v;
  logic pready, pslverr, tick, e;
  logic rpin_n = 1'b1, ipin_n = 1'b1, tpin = 1'b0, lv = 1'b0;
  logic run = 1'b0, software_trap_instruction = 1'b0, clr = 1'b0, set = 1'b0;
  logic saw_rst = 1'b0;
  logic [10:0] stk = 11'h000;
  rits_cpu_req_t cpu;
  rits_seq_out_t seq;
  int fail_count = 0, tests_run = 0, lat = 0, ticks = 0, t = 0;
  int seed = 32'ha5c17379;
  logic [10:0] vq[$];
  int lq[$];

  always #10 clk = ~clk;

  rits_sequencer dut (.i_clock(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_reset_pin_n(rpin_n), .i_int_pin_n(ipin_n),
    .i_timer_pin(tpin), .i_low_voltage(lv), .i_cpu(cpu), .o_seq(seq),
    .o_sys_tick(tick));
  rits_cpu_model cpu_m (.i_clock(clk), .i_rst_n(rst_n), .i_run(run),
    .i_swi(software_trap_instruction), .i_clr(clr), .i_set(set), .i_seq(seq), .o_cpu(cpu));
  // second build: timer clocked by pin edges through a divide-by-two
  rits_sequencer #(.PRESCALE_LOG2(3'd1), .TIMER_SRC_EXT(1'b1),
    .LVD_ENABLE(1'b1)) dut2 (.i_clock(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata2), .o_pready(), .o_pslverr(),
    .i_reset_pin_n(rpin_n), .i_int_pin_n(ipin_n), .i_timer_pin(tpin),
    .i_low_voltage(lv), .i_cpu(cpu), .o_seq(), .o_sys_tick());

  // ----------------------------------------
  // monitor, sampled mid-cycle where outputs are settled
  // ----------------------------------------
  always @(negedge clk) begin
    if (tick === 1'b1) ticks++;
    if (seq.in_reset === 1'b1) begin
      saw_rst = 1'b1;
      stk = seq.stack_init;
    end
    if (seq.busy === 1'b1 || seq.vec_load === 1'b1) lat++;
    if (seq.vec_load === 1'b1) begin
      vq.push_back(seq.vec_addr);
      lq.push_back(lat);
      lat = 0;
    end
  end

  // ----------------------------------------
  // reference model and checks
  // ----------------------------------------
  function automatic logic [10:0] pick(input bit x, tm, m, s);
    if (!m && x) return VEC_EXT;
    if (!m && tm) return VEC_TIMER;
    return s ? VEC_SWI : VEC_RESET;
  endfunction
  function automatic logic [31:0] stat(input bit m, x, p, tm);
    return {27'h0, tm, 1'b0, p, x, m};
  endfunction

  task check_word(input string what, input logic [31:0] exp,
                  input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task check_span(input string what, input int lo, input int hi,
                  input logic [31:0] got);
    tests_run++;
    if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
      fail_count++;
      $display("wrong value %s expected %0d..%0d seen %h", what, lo, hi, got);
    end
  endtask
  task wrap_up;
    if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // hold the request until pready is seen high at a rising edge
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    r2 = prdata2;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    check_word(what, exp, r);
  endtask
  task take(input logic [10:0] exp);
    int n;
    n = 0;
    while (vq.size() == 0 && n < 600) begin
      @(posedge clk);
      n++;
    end
    if (vq.size() == 0) check_word("vector count", 32'h1, 32'h0);
    else begin
      check_word("vector", 32'(exp), 32'(vq.pop_front()));
      n = lq.pop_front();
      if (exp != VEC_RESET) check_span("service clocks", 40, 48, 32'(n));
    end
  endtask
  task wait_n(input int k);
    int n;
    n = 0;
    while (vq.size() < k && n < 900) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    run <= 1'b0;
  endtask
  task cmd(input logic c, input logic s, input logic m);
    @(posedge clk);
    clr <= c;
    software_trap_instruction <= s;
    set <= m;
    @(posedge clk);
    {clr, software_trap_instruction, set} <= 3'b000;
    repeat (4) @(posedge clk);
    run <= 1'b1;
  endtask
  task pin_reset(input int n);
    saw_rst = 1'b0;
    @(posedge clk) rpin_n <= 1'b0;
    repeat (n) @(posedge clk);
    rpin_n <= 1'b1;
    repeat (10) @(posedge clk);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    wrap_up;
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    take(VEC_RESET);
    rd(ADDR_COUNT, 32'hff, "count");
    rd(ADDR_CTRL, 32'h7f, "control");
    rd(ADDR_STAT, stat(1, 0, 1, 0), "status");
    check_word("pin level", 32'h1, 32'(seq.int_level));
    check_word("stack init", 32'(SP_RESET), 32'(seq.stack_init));
    t = ticks;
    repeat (40) @(posedge clk);
    check_word("system ticks", 32'd10, 32'(ticks - t));
    repeat (6) begin
      v = $random(seed);
      apb(1'b1, ADDR_COUNT, v);
      rd(ADDR_COUNT, v & 32'hff, "count echo");
    end
    apb(1'b0, 12'h00c, 32'h0);
    check_word("unmapped error", 32'h1, 32'(e));
    apb(1'b1, ADDR_STAT, 32'h0);
    check_word("status write error", 32'h1, 32'(e));
    // four open windows of one system cycle: four rising pin edges
    apb(1'b1, ADDR_COUNT, 32'h3);
    repeat (4) begin
      @(posedge clk) tpin <= 1'b1;
      repeat (4) @(posedge clk);
      tpin <= 1'b0;
      repeat (3) @(posedge clk);
    end
    apb(1'b0, ADDR_COUNT, 32'h0);
    check_word("window count", 32'hff, r);
    check_word("external count", 32'h1, r2);
    pin_reset(4);
    check_word("short pin reset", 32'h0, 32'(saw_rst));
    // timer: gate closed, then open for ten system cycles
    apb(1'b1, ADDR_COUNT, 32'h3);
    apb(1'b1, ADDR_CTRL, 32'h0);
    repeat (40) @(posedge clk);
    rd(ADDR_COUNT, 32'h3, "gated count");
    @(posedge clk) tpin <= 1'b1;
    repeat (40) @(posedge clk);
    tpin <= 1'b0;
    apb(1'b0, ADDR_COUNT, 32'h0);
    check_span("wrapped count", 'hf8, 'hfb, r);
    rd(ADDR_CTRL, 32'hbf, "control");
    rd(ADDR_STAT, stat(1, 0, 1, 1), "status");
    apb(1'b1, ADDR_CTRL, 32'hc0);
    rd(ADDR_CTRL, 32'hff, "control");
    rd(ADDR_STAT, stat(1, 0, 1, 0), "status");
    apb(1'b1, ADDR_CTRL, 32'h80);
    rd(ADDR_CTRL, 32'hbf, "control");
    // processor mask holds the pending timer request back; pin edge latched after the run stops
    @(posedge clk) run <= 1'b1;
    repeat (80) @(posedge clk);
    check_word("masked services", 32'h0, 32'(vq.size()));
    run <= 1'b0;
    @(posedge clk) ipin_n <= 1'b0;
    repeat (6) @(posedge clk);
    check_word("pin level", 32'h0, 32'(seq.int_level));
    rd(ADDR_STAT, stat(1, 1, 0, 1), "status");
    cmd(1'b1, 1'b0, 1'b0);
    wait_n(2);
    take(pick(1, 1, 0, 0));
    take(pick(0, 1, 0, 0));
    apb(1'b1, ADDR_CTRL, 32'h40);
    // trap with mask set, then trap behind a pending pin request
    cmd(1'b0, 1'b1, 1'b1);
    wait_n(1);
    take(pick(0, 0, 1, 1));
    @(posedge clk) ipin_n <= 1'b1;
    repeat (6) @(posedge clk);
    ipin_n <= 1'b0;
    repeat (6) @(posedge clk);
    cmd(1'b1, 1'b1, 1'b0);
    wait_n(2);
    take(pick(1, 0, 0, 1));
    take(pick(0, 0, 0, 1));
    @(posedge clk) ipin_n <= 1'b1;
    // shortest pulse that is longer than one system cycle
    pin_reset(5);
    check_word("pin reset", 32'h1, 32'(saw_rst));
    check_word("stack init", 32'(SP_RESET), 32'(stk));
    take(VEC_RESET);
    rd(ADDR_CTRL, 32'h7f, "control");
    rd(ADDR_STAT, stat(1, 0, 1, 0), "status");
    saw_rst = 1'b0;
    @(posedge clk) lv <= 1'b1;
    repeat (8) @(posedge clk);
    lv <= 1'b0;
    take(VEC_RESET);
    check_word("low voltage reset", 32'h1, 32'(saw_rst));
    wrap_up;
  end
endmodule

// >>> verilog/rits_pkg.sv
package rits_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int T_CLOCK_NS = 20;
  localparam int OSC_PER_SYS = 4;
  localparam int T_SYS_NS = OSC_PER_SYS * T_CLOCK_NS;
  // pin must stay low longer than one system cycle
  localparam logic [2:0] RSTPIN_LOW_CLK = 3'(T_SYS_NS / T_CLOCK_NS + 1);
  localparam logic [3:0] SERVICE_CYCLES = 4'hb;

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [11:0] ADDR_COUNT = 12'h000;
  localparam logic [11:0] ADDR_CTRL = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h008;

  localparam int CTRL_REQ_BIT = 7;
  localparam int CTRL_MASK_BIT = 6;
  localparam logic [5:0] CTRL_UNUSED = 6'h3f;

  localparam int STAT_MASK_BIT = 0;
  localparam int STAT_EXT_BIT = 1;
  localparam int STAT_PIN_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;
  localparam int STAT_TIRQ_BIT = 4;

  // ------------------------------------------------------------
  // reset values and vectors
  // ------------------------------------------------------------
  localparam logic [7:0] COUNT_RESET = 8'hff;
  localparam logic [6:0] PRESC_RESET = 7'h7f;
  localparam logic [10:0] SP_RESET = 11'h07f;
  localparam logic [10:0] VEC_RESET = 11'h7fe;
  localparam logic [10:0] VEC_SWI = 11'h7fc;
  localparam logic [10:0] VEC_EXT = 11'h7fa;
  localparam logic [10:0] VEC_TIMER = 11'h7f8;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_RSTVEC = 2'b01,
    ST_RUN = 2'b11,
    ST_SERVICE = 2'b10
  } rits_state_t;

  typedef struct packed {
    logic boundary;
    logic software_trap_instruction;
    logic mask_set;
    logic mask_clr;
  } rits_cpu_req_t;

  typedef struct packed {
    logic in_reset;
    logic vec_load;
    logic [10:0] vec_addr;
    logic [10:0] stack_init;
    logic mask;
    logic busy;
    logic int_level;
  } rits_seq_out_t;

endpackage

// >>> verilog/rits_sequencer.sv
`timescale 1ns/1ps
// Contract
// - counter wraps from zero to ff and keeps counting down
// - reading the counter never disturbs, pauses or reloads it
// - reset loads prescaler and counter with ones, clears request, sets mask
// - build-time prescaler divides timer input by up to 128
// - internal clock source is gated by the timer pin level
// - system cycle is the oscillator clock divided by four
// - reset comes from power-up, reset pin, or optional low-voltage detect
// - reset pin low only longer than one system cycle resets
// - service stacks state, sets mask, fetches vector in 11 cycles
// - hardware interrupt waits for the instruction boundary
// - masked requests stay latched; none pending means normal fetch
// - external interrupt wins over timer at the same boundary
// - interrupt pin synchronised, request latched on falling edge
// - software trap ignores mask; pending unmasked hardware goes first
// - vectors: trap 7fc, external 7fa, timer 7f8
// - reset sets mask, stack 07f, clears latch, timer values
// - reset release loads program counter from vector 7fe
// - interrupt pin level readable for polling branches
// - counter reaching zero sets request flag bit 7
// - control bit 6 or processor mask blocks the timer interrupt
// - control bits 5 to 0 read as ones
module rits_sequencer #(
  parameter logic [2:0] PRESCALE_LOG2 = 3'd0,
  parameter logic TIMER_SRC_EXT = 1'b0,
  parameter logic LVD_ENABLE = 1'b1
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // pins
  input wire logic i_reset_pin_n,
  input wire logic i_int_pin_n,
  input wire logic i_timer_pin,
  input wire logic i_low_voltage,
  // cpu core
  input wire rits_pkg::rits_cpu_req_t i_cpu,
  output rits_pkg::rits_seq_out_t o_seq,
  output logic o_sys_tick
);
  import rits_pkg::*;

  // ------------------------------------------------------------
  // reset release and pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [1:0] rpin_s_q, ipin_s_q, tpin_s_q, lvd_s_q;
  logic ipin_prev_q, tpin_prev_q;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      rpin_s_q <= 2'b11;
      ipin_s_q <= 2'b11;
      tpin_s_q <= 2'b00;
      lvd_s_q <= 2'b00;
      ipin_prev_q <= 1'b1;
      tpin_prev_q <= 1'b0;
    end else begin
      rpin_s_q <= {rpin_s_q[0], i_reset_pin_n};
      ipin_s_q <= {ipin_s_q[0], i_int_pin_n};
      tpin_s_q <= {tpin_s_q[0], i_timer_pin};
      lvd_s_q <= {lvd_s_q[0], i_low_voltage};
      ipin_prev_q <= ipin_s_q[1];
      tpin_prev_q <= tpin_s_q[1];
    end
  end

  wire ipin = ipin_s_q[1];
  wire tpin = tpin_s_q[1];
  wire int_fall = ipin_prev_q & ~ipin;
  wire tpin_rise = tpin & ~tpin_prev_q;

  // ------------------------------------------------------------
  // system cycle divider
  // ------------------------------------------------------------
  logic [1:0] div_q;
  logic sys_ce;

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 2'd0;
    end else begin
      div_q <= div_q + 2'd1;
    end
  end
  assign sys_ce = (div_q == 2'(OSC_PER_SYS - 1));

  // ------------------------------------------------------------
  // internal reset: pin filter and low-voltage detect
  // ------------------------------------------------------------
  logic [2:0] rlow_q;
  logic sys_rst_q;
  wire rpin_low = ~rpin_s_q[1];
  // rlow_q counts earlier low samples, so the limit-th low sample resets
  wire rpin_long = (rlow_q == RSTPIN_LOW_CLK - 3'd1);
  wire lvd_hit = LVD_ENABLE & lvd_s_q[1];

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      rlow_q <= 3'd0;
      sys_rst_q <= 1'b1;
    end else begin
      // short glitches restart the count and never reach the limit
      if (!rpin_low) begin
        rlow_q <= 3'd0;
      end else if (!rpin_long) begin
        rlow_q <= rlow_q + 3'd1;
      end
      sys_rst_q <= (rpin_low & rpin_long) | lvd_hit;
    end
  end
  // internal reset holds while the pin stays low or low voltage is detected
  wire sys_rst = sys_rst_q;

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic pready_q;
  wire apb_acc = i_psel & i_penable;
  wire apb_done = apb_acc & pready_q;
  wire hit_count = (i_paddr == ADDR_COUNT);
  wire hit_ctrl = (i_paddr == ADDR_CTRL);
  wire hit_stat = (i_paddr == ADDR_STAT);
  wire hit_any = hit_count | hit_ctrl | hit_stat;
  wire wr_count = apb_done & i_pwrite & hit_count;
  wire wr_ctrl = apb_done & i_pwrite & hit_ctrl;

  // ------------------------------------------------------------
  // timer prescaler and counter
  // ------------------------------------------------------------
  logic [6:0] presc_q;
  logic [7:0] count_q;
  logic treq_q, tmask_q;
  localparam logic [6:0] PRESC_MASK = 7'((8'h01 << PRESCALE_LOG2) - 8'h01);

  // gated internal clock allows pulse-width measurement
  wire tick_int = sys_ce & tpin;
  wire tick_ext = tpin_rise;
  wire tmr_tick = TIMER_SRC_EXT ? tick_ext : tick_int;
  wire presc_wrap = ((presc_q & PRESC_MASK) == 7'h00);
  wire cnt_dec = tmr_tick & presc_wrap;
  wire cnt_zero = cnt_dec & (count_q == 8'h01) & ~wr_count;
  wire treq_clr = wr_ctrl & ~i_pwdata[CTRL_REQ_BIT];

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      presc_q <= PRESC_RESET;
      count_q <= COUNT_RESET;
      treq_q <= 1'b0;
      tmask_q <= 1'b1;
    end else if (sys_rst) begin
      presc_q <= PRESC_RESET;
      count_q <= COUNT_RESET;
      treq_q <= 1'b0;
      tmask_q <= 1'b1;
    end else begin
      if (tmr_tick) begin
        presc_q <= presc_q - 7'h01;
      end
      if (wr_count) begin
        count_q <= i_pwdata[7:0];
      end else if (cnt_dec) begin
        count_q <= count_q - 8'h01;
      end
      // a new zero crossing wins over a software clear
      if (cnt_zero) begin
        treq_q <= 1'b1;
      end else if (treq_clr) begin
        treq_q <= 1'b0;
      end
      if (wr_ctrl) begin
        tmask_q <= i_pwdata[CTRL_MASK_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // external interrupt latch and processor mask
  // ------------------------------------------------------------
  logic ext_q, mask_q;
  rits_state_t state_q, state_d;
  logic [3:0] svc_q;
  logic [10:0] vec_q;

  wire timer_irq = treq_q & ~tmask_q;
  wire at_bound = (state_q == ST_RUN) & i_cpu.boundary;
  wire take_ext = at_bound & ~mask_q & ext_q;
  wire take_tmr = at_bound & ~mask_q & ~ext_q & timer_irq;
  wire take_swi = at_bound & i_cpu.software_trap_instruction & ~take_ext & ~take_tmr;
  wire take_any = take_ext | take_tmr | take_swi;
  wire svc_end = (state_q == ST_SERVICE) & sys_ce & (svc_q == 4'd1);

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_q <= 1'b0;
      mask_q <= 1'b1;
    end else if (sys_rst) begin
      ext_q <= 1'b0;
      mask_q <= 1'b1;
    end else begin
      // masked edges stay latched until serviced
      if (int_fall) begin
        ext_q <= 1'b1;
      end else if (take_ext) begin
        ext_q <= 1'b0;
      end
      if (take_any | i_cpu.mask_set) begin
        mask_q <= 1'b1;
      end else if (i_cpu.mask_clr) begin
        mask_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_RESET: begin
        state_d = ST_RSTVEC;
      end
      ST_RSTVEC: begin
        if (sys_ce) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (take_any) begin
          state_d = ST_SERVICE;
        end
      end
      ST_SERVICE: begin
        if (svc_end) begin
          state_d = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_RESET;
      svc_q <= 4'd0;
      vec_q <= VEC_RESET;
    end else if (sys_rst) begin
      state_q <= ST_RESET;
      svc_q <= 4'd0;
      vec_q <= VEC_RESET;
    end else begin
      state_q <= state_d;
      if (take_any) begin
        svc_q <= SERVICE_CYCLES;
        vec_q <= take_ext ? VEC_EXT : (take_tmr ? VEC_TIMER : VEC_SWI);
      end else if (state_q == ST_SERVICE && sys_ce) begin
        svc_q <= svc_q - 4'd1;
      end
    end
  end
  // vector choice above follows the source priority

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  wire [7:0] ctrl_rd = {treq_q, tmask_q, CTRL_UNUSED};
  wire [7:0] stat_rd = {3'h0, timer_irq, state_q == ST_SERVICE, ipin,
                        ext_q, mask_q};
  wire [7:0] rd_mux = hit_count ? count_q :
                      (hit_ctrl ? ctrl_rd : (hit_stat ? stat_rd : 8'h00));
  wire vec_pulse = svc_end | ((state_q == ST_RSTVEC) & sys_ce);

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
      o_seq <= '0;
      o_sys_tick <= 1'b0;
    end else begin
      // one wait state: answer in the second access cycle
      pready_q <= apb_acc & ~pready_q;
      if (apb_acc & ~pready_q) begin
        o_prdata <= {24'h00_0000, i_pwrite ? 8'h00 : rd_mux};
        o_pslverr <= ~hit_any | (i_pwrite & hit_stat);
      end
      o_seq.in_reset <= sys_rst | (state_q == ST_RESET);
      o_seq.vec_load <= vec_pulse & ~sys_rst;
      o_seq.vec_addr <= vec_q;
      o_seq.stack_init <= SP_RESET;
      o_seq.mask <= mask_q;
      o_seq.busy <= (state_q != ST_RUN);
      o_seq.int_level <= ipin;
      o_sys_tick <= sys_ce;
    end
  end
  assign o_pready = pready_q;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_count_wrap: assert property (@(posedge i_clock)
    disable iff (!rst_n)
    (cnt_dec && !wr_count && !sys_rst && count_q == 8'h00)
      |=> count_q == 8'hff)
    else $error("counter did not wrap to ff");

  a_read_no_disturb: assert property (@(posedge i_clock)
    disable iff (!rst_n)
    (apb_done && !i_pwrite && !cnt_dec && !sys_rst) |=> $stable(count_q))
    else $error("read disturbed counter");

  a_reset_values: assert property (@(posedge i_clock)
    disable iff (!rst_n)
    sys_rst |=> (count_q == 8'hff && presc_q == 7'h7f && !treq_q
                 && tmask_q && mask_q && !ext_q))
    else $error("reset values wrong");

  a_sys_divider: assert property (@(posedge i_clock)
    disable iff (!rst_n)
    sys_ce |=> !sys_ce ##1 !sys_ce ##1 !sys_ce ##1 sys_ce)
    else $error("system cycle not four clocks");

  a_pin_filter: assert property (@(posedge i_clock)
    disable iff (!rst_n)
    (!rpin_low ##1 rpin_low [*4] ##1 !rpin_low && !lvd_hit)
      |-> ##1 !sys_rst_q)
    else $error("short reset pulse accepted");

  a_service_len: assert property (@(posedge i_clock)
    disable iff (!rst_n)
    (take_any && !sys_rst) |-> ##[41:48] (state_q == ST_RUN))
    else $error("service length wrong");

  a_ext_first: assert property (@(posedge i_clock)
    disable iff (!rst_n)
    (at_bound && !mask_q && ext_q && !sys_rst) |=> vec_q == VEC_EXT)
    else $error("external not served first");

  a_masked_held: assert property (@(posedge i_clock)
    disable iff (!rst_n)
    (ext_q && mask_q && !sys_rst) |=> ext_q)
    else $error("masked request lost");

  a_timer_flag: assert property (@(posedge i_clock)
    disable iff (!rst_n)
    (cnt_zero && !sys_rst) |=> (treq_q && count_q == 8'h00))
    else $error("timer flag not set at zero");

  a_timer_block: assert property (@(posedge i_clock)
    disable iff (!rst_n)
    (tmask_q || mask_q) |-> !take_tmr)
    else $error("masked timer taken");

  a_ext_edge: assert property (@(posedge i_clock)
    disable iff (!rst_n)
    (int_fall && !sys_rst) |=> ext_q)
    else $error("falling edge not latched");

  a_reset_vector: assert property (@(posedge i_clock)
    disable iff (!rst_n)
    (state_q == ST_RSTVEC && sys_ce && !sys_rst)
      |=> (o_seq.vec_load && o_seq.vec_addr == VEC_RESET))
    else $error("reset vector not fetched");

endmodule
